/* logic/ookm_config.sv */
// What this block does
// - Filter exponent, skip, select from one register
// - Keyed mode when modulation kind equals code
// - Keyed mode configures rate, coding, filter, ratio
// - Data rate is sixteen bits, two registers
// - Manchester flag enables coding, doubles effective rate
// - Oversampling ratio eleven bits across two registers
// - Keyed mode flags (bw_valid) whether the filter is in the reduced bandwidth list; any setting is still applied
`timescale 1ns/1ns
`default_nettype none

module ookm_config (
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ookm_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic                             pready,
    output logic      [31:0]                 prdata,
    output logic                             pslverr,
    output logic                             ook_mode,
    output logic                             third_stage_skip,
    output logic      [2:0]                  decim_exp,
    output logic      [3:0]                  filter_sel,
    output logic                             bw_valid,
    output logic      [15:0]                 rate_word,
    output logic                             rate_scale,
    output logic                             manchester_en,
    output logic      [16:0]                 eff_rate,
    output logic      [10:0]                 osr_ratio,
    output logic      [19:0]                 nco_offset,
    output logic      [10:0]                 loop_gain
);

    typedef struct packed {
        ookm_pkg::ookm_bus_state_type st;
        logic                         pready;
        logic [31:0]                  prdata;
        logic                         pslverr;
        logic [7:0]                   r_filter;
        logic [7:0]                   r_osr;
        logic [7:0]                   r_off_hi;
        logic [7:0]                   r_off_mid;
        logic [7:0]                   r_off_lo;
        logic [7:0]                   r_gain_hi;
        logic [7:0]                   r_gain_lo;
        logic [7:0]                   r_rate_hi;
        logic [7:0]                   r_rate_lo;
        logic [7:0]                   r_mod1;
        logic [7:0]                   r_mod2;
        logic                         on_off_keying;
        logic                         skip;
        logic [2:0]                   dexp;
        logic [3:0]                   fsel;
        logic [15:0]                  rate;
        logic                         rscale;
        logic                         manch;
        logic [16:0]                  eff;
        logic [10:0]                  osr;
        logic [19:0]                  nco;
        logic [10:0]                  gain;
    } ookm_cfg_state_type;

    ookm_cfg_state_type cur_ff;
    ookm_cfg_state_type nxt_cur;

    logic [7:0]  idx;
    logic        addr_ok;
    logic        wr_any;
    logic        wr_filter;
    logic        wr_osr;
    logic        wr_off_hi;
    logic        wr_off_mid;
    logic        wr_off_lo;
    logic        wr_gain_hi;
    logic        wr_gain_lo;
    logic        wr_rate_hi;
    logic        wr_rate_lo;
    logic        wr_mod1;
    logic        wr_mod2;
    logic        rate_commit;
    logic        osr_commit;
    logic        nco_commit;
    logic        gain_commit;
    logic [1:0]  rate_pend;
    logic [1:0]  osr_pend;
    logic [2:0]  nco_pend;
    logic [1:0]  gain_pend;
    logic        bw_ok;
    logic [31:0] rd_word;

    // Word-aligned decode; stray low address bits make the access unmapped
    assign idx     = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[ookm_pkg::ADDR_W-1:10] == '0);

    // A write lands only at the edge where the master sees pready high
    assign wr_any     = (cur_ff.st == ookm_pkg::ST_RESP) && pwrite && pstrb[0] && addr_ok;
    assign wr_filter  = wr_any && (idx == ookm_pkg::IDX_FILTER);
    assign wr_osr     = wr_any && (idx == ookm_pkg::IDX_OSR);
    assign wr_off_hi  = wr_any && (idx == ookm_pkg::IDX_OFF_HI);
    assign wr_off_mid = wr_any && (idx == ookm_pkg::IDX_OFF_MID);
    assign wr_off_lo  = wr_any && (idx == ookm_pkg::IDX_OFF_LO);
    assign wr_gain_hi = wr_any && (idx == ookm_pkg::IDX_GAIN_HI);
    assign wr_gain_lo = wr_any && (idx == ookm_pkg::IDX_GAIN_LO);
    assign wr_rate_hi = wr_any && (idx == ookm_pkg::IDX_RATE_HI);
    assign wr_rate_lo = wr_any && (idx == ookm_pkg::IDX_RATE_LO);
    assign wr_mod1    = wr_any && (idx == ookm_pkg::IDX_MOD_ONE);
    assign wr_mod2    = wr_any && (idx == ookm_pkg::IDX_MOD_TWO);

    // Completion trackers; the shared offset-high byte feeds two of them
    ookm_commit #(.PARTS(2)) u_rate_commit (
        .clk_sys (clk_sys),
        .rst     (rst),
        .part_wr ({wr_rate_hi, wr_rate_lo}),
        .commit  (rate_commit),
        .pending (rate_pend)
    );

    ookm_commit #(.PARTS(2)) u_osr_commit (
        .clk_sys (clk_sys),
        .rst     (rst),
        .part_wr ({wr_off_hi, wr_osr}),
        .commit  (osr_commit),
        .pending (osr_pend)
    );

    ookm_commit #(.PARTS(3)) u_nco_commit (
        .clk_sys (clk_sys),
        .rst     (rst),
        .part_wr ({wr_off_hi, wr_off_mid, wr_off_lo}),
        .commit  (nco_commit),
        .pending (nco_pend)
    );

    ookm_commit #(.PARTS(2)) u_gain_commit (
        .clk_sys (clk_sys),
        .rst     (rst),
        .part_wr ({wr_gain_hi, wr_gain_lo}),
        .commit  (gain_commit),
        .pending (gain_pend)
    );

    ookm_bw_check u_bw_check (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .ook_mode (cur_ff.on_off_keying),
        .skip     (cur_ff.skip),
        .fsel     (cur_ff.fsel),
        .valid    (bw_ok)
    );

    // Read multiplexer; the raw bytes read back even before a field commits
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (idx)
            ookm_pkg::IDX_FILTER:  rd_word[7:0] = cur_ff.r_filter;
            ookm_pkg::IDX_OSR:     rd_word[7:0] = cur_ff.r_osr;
            ookm_pkg::IDX_OFF_HI:  rd_word[7:0] = cur_ff.r_off_hi;
            ookm_pkg::IDX_OFF_MID: rd_word[7:0] = cur_ff.r_off_mid;
            ookm_pkg::IDX_OFF_LO:  rd_word[7:0] = cur_ff.r_off_lo;
            ookm_pkg::IDX_GAIN_HI: rd_word[7:0] = cur_ff.r_gain_hi;
            ookm_pkg::IDX_GAIN_LO: rd_word[7:0] = cur_ff.r_gain_lo;
            ookm_pkg::IDX_RATE_HI: rd_word[7:0] = cur_ff.r_rate_hi;
            ookm_pkg::IDX_RATE_LO: rd_word[7:0] = cur_ff.r_rate_lo;
            ookm_pkg::IDX_MOD_ONE: rd_word[7:0] = cur_ff.r_mod1;
            ookm_pkg::IDX_MOD_TWO: rd_word[7:0] = cur_ff.r_mod2;
            ookm_pkg::IDX_STATUS:  rd_word[10:0] = {nco_pend, gain_pend, osr_pend,
                                                    rate_pend, bw_ok, cur_ff.on_off_keying};
            default:               rd_word = 32'h0000_0000;
        endcase
    end

    // Bus sequencing and register update
    always_comb begin
        nxt_cur         = cur_ff;
        nxt_cur.pready  = 1'b0;
        nxt_cur.pslverr = 1'b0;
        unique case (cur_ff.st)
            ookm_pkg::ST_IDLE: begin
                if (psel && !penable) begin
                    nxt_cur.st = ookm_pkg::ST_ACC;
                end
            end
            ookm_pkg::ST_ACC: begin
                // One wait state gives registered pready and prdata
                if (psel && penable) begin
                    nxt_cur.st      = ookm_pkg::ST_RESP;
                    nxt_cur.pready  = 1'b1;
                    nxt_cur.pslverr = !addr_ok || (rd_word == 32'h0 && !(
                        idx == ookm_pkg::IDX_FILTER  || idx == ookm_pkg::IDX_OSR     ||
                        idx == ookm_pkg::IDX_OFF_HI  || idx == ookm_pkg::IDX_OFF_MID ||
                        idx == ookm_pkg::IDX_OFF_LO  || idx == ookm_pkg::IDX_GAIN_HI ||
                        idx == ookm_pkg::IDX_GAIN_LO || idx == ookm_pkg::IDX_RATE_HI ||
                        idx == ookm_pkg::IDX_RATE_LO || idx == ookm_pkg::IDX_MOD_ONE ||
                        idx == ookm_pkg::IDX_MOD_TWO || idx == ookm_pkg::IDX_STATUS));
                    nxt_cur.prdata  = pwrite ? 32'h0000_0000 : (addr_ok ? rd_word : 32'h0);
                end
            end
            ookm_pkg::ST_RESP: begin
                nxt_cur.st = ookm_pkg::ST_IDLE;
            end
            default: begin
                nxt_cur.st = ookm_pkg::ST_IDLE;
            end
        endcase

        // Raw byte storage
        if (wr_filter)  nxt_cur.r_filter  = pwdata[7:0];
        if (wr_osr)     nxt_cur.r_osr     = pwdata[7:0];
        if (wr_off_hi)  nxt_cur.r_off_hi  = pwdata[7:0];
        if (wr_off_mid) nxt_cur.r_off_mid = pwdata[7:0];
        if (wr_off_lo)  nxt_cur.r_off_lo  = pwdata[7:0];
        if (wr_gain_hi) nxt_cur.r_gain_hi = pwdata[7:0];
        if (wr_gain_lo) nxt_cur.r_gain_lo = pwdata[7:0];
        if (wr_rate_hi) nxt_cur.r_rate_hi = pwdata[7:0];
        if (wr_rate_lo) nxt_cur.r_rate_lo = pwdata[7:0];
        if (wr_mod1)    nxt_cur.r_mod1    = pwdata[7:0];
        if (wr_mod2)    nxt_cur.r_mod2    = pwdata[7:0];

        // Single-byte settings take effect with the write itself
        nxt_cur.skip   = nxt_cur.r_filter[ookm_pkg::FILT_SKIP_BIT];
        nxt_cur.dexp   = nxt_cur.r_filter[ookm_pkg::FILT_EXP_LSB +: 3];
        nxt_cur.fsel   = nxt_cur.r_filter[ookm_pkg::FILT_SEL_LSB +: 4];
        nxt_cur.on_off_keying    = nxt_cur.r_mod2[ookm_pkg::MOD2_KIND_LSB +: 2] == ookm_pkg::KIND_OOK;
        nxt_cur.rscale = nxt_cur.r_mod1[ookm_pkg::MOD1_SCALE_BIT];
        nxt_cur.manch  = nxt_cur.r_mod1[ookm_pkg::MOD1_MANCH_BIT];

        // Split fields move only after all their bytes are in
        if (rate_commit) begin
            nxt_cur.rate = {cur_ff.r_rate_hi, cur_ff.r_rate_lo};
        end
        if (osr_commit) begin
            nxt_cur.osr = {cur_ff.r_off_hi[ookm_pkg::OSR_HI_LSB +: 3], cur_ff.r_osr};
        end
        if (nco_commit) begin
            nxt_cur.nco = {cur_ff.r_off_hi[ookm_pkg::NCO_HI_LSB +: 4],
                           cur_ff.r_off_mid, cur_ff.r_off_lo};
        end
        if (gain_commit) begin
            nxt_cur.gain = {cur_ff.r_gain_hi[ookm_pkg::GAIN_HI_LSB +: 3],
                            cur_ff.r_gain_lo};
        end

        // Coding doubles the line rate the recovery loop must track
        nxt_cur.eff = nxt_cur.manch ? {nxt_cur.rate, 1'b0} : {1'b0, nxt_cur.rate};
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur_ff           <= '0;
            cur_ff.st        <= ookm_pkg::ST_IDLE;
            cur_ff.r_filter  <= ookm_pkg::REG_RESET;
            cur_ff.r_osr     <= ookm_pkg::REG_RESET;
            cur_ff.r_off_hi  <= ookm_pkg::REG_RESET;
            cur_ff.r_off_mid <= ookm_pkg::REG_RESET;
            cur_ff.r_off_lo  <= ookm_pkg::REG_RESET;
            cur_ff.r_gain_hi <= ookm_pkg::REG_RESET;
            cur_ff.r_gain_lo <= ookm_pkg::REG_RESET;
            cur_ff.r_rate_hi <= ookm_pkg::REG_RESET;
            cur_ff.r_rate_lo <= ookm_pkg::REG_RESET;
            cur_ff.r_mod1    <= ookm_pkg::REG_RESET;
            cur_ff.r_mod2    <= ookm_pkg::REG_RESET;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Outputs straight from flip-flops
    assign pready           = cur_ff.pready;
    assign prdata           = cur_ff.prdata;
    assign pslverr          = cur_ff.pslverr;
    assign ook_mode         = cur_ff.on_off_keying;
    assign third_stage_skip = cur_ff.skip;
    assign decim_exp        = cur_ff.dexp;
    assign filter_sel       = cur_ff.fsel;
    assign bw_valid         = bw_ok;
    assign rate_word        = cur_ff.rate;
    assign rate_scale       = cur_ff.rscale;
    assign manchester_en    = cur_ff.manch;
    assign eff_rate         = cur_ff.eff;
    assign osr_ratio        = cur_ff.osr;
    assign nco_offset       = cur_ff.nco;
    assign loop_gain        = cur_ff.gain;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_setup;
        psel && !penable && cur_ff.st == ookm_pkg::ST_IDLE;
    endsequence

    sequence s_access;
        psel && penable;
    endsequence

    sequence s_answer;
        pready ##1 !pready;
    endsequence

    AST_APB_ANSWER: assert property (s_setup ##1 s_access |=> s_answer)
        else $error("pready did not pulse one cycle after access");

    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr raised outside an answer");

    AST_FILTER_FIELDS: assert property (wr_filter |=>
        filter_sel == $past(pwdata[3:0]) && decim_exp == $past(pwdata[6:4])
        && third_stage_skip == $past(pwdata[7]))
        else $error("filter fields did not follow the write");

    AST_KIND_OOK: assert property (wr_mod2 |=>
        ook_mode == ($past(pwdata[1:0]) == ookm_pkg::KIND_OOK))
        else $error("keyed mode flag wrong after kind write");

    AST_RATE_COMMIT: assert property (wr_rate_hi && rate_pend[0] |=> ##1
        rate_word == {$past(pwdata[7:0], 2), cur_ff.r_rate_lo})
        else $error("data rate word not applied after both bytes");

    AST_EFF_RATE: assert property (##1 manchester_en && $stable(rate_word)
        |-> eff_rate == {rate_word, 1'b0})
        else $error("effective rate not doubled with coding on");

    AST_OSR_COMMIT: assert property (osr_commit |=>
        osr_ratio == $past({cur_ff.r_off_hi[7:5], cur_ff.r_osr}))
        else $error("oversampling ratio not assembled on commit");

    AST_BW_NEEDS_OOK: assert property (!ook_mode [*2] |-> !bw_valid)
        else $error("bandwidth flagged valid outside keyed mode");

    AST_HALF_WRITE: assert property (!rate_commit && !gain_commit |=>
        $stable(rate_word) && $stable(loop_gain))
        else $error("split field changed without a full write");

endmodule

`default_nettype wire

/* logic/ookm_pkg.sv */
`default_nettype none

package ookm_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_FILTER   = 8'h1c;
    localparam logic [7:0] IDX_OSR      = 8'h20;
    localparam logic [7:0] IDX_OFF_HI   = 8'h21;
    localparam logic [7:0] IDX_OFF_MID  = 8'h22;
    localparam logic [7:0] IDX_OFF_LO   = 8'h23;
    localparam logic [7:0] IDX_GAIN_HI  = 8'h24;
    localparam logic [7:0] IDX_GAIN_LO  = 8'h25;
    localparam logic [7:0] IDX_RATE_HI  = 8'h6e;
    localparam logic [7:0] IDX_RATE_LO  = 8'h6f;
    localparam logic [7:0] IDX_MOD_ONE  = 8'h70;
    localparam logic [7:0] IDX_MOD_TWO  = 8'h71;
    localparam logic [7:0] IDX_STATUS   = 8'h30;

    // Byte address width of the register bus
    localparam int ADDR_W = 12;

    // Reset value of every configuration byte
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field positions in the filter bandwidth register
    localparam int FILT_SEL_LSB  = 0;
    localparam int FILT_EXP_LSB  = 4;
    localparam int FILT_SKIP_BIT = 7;

    // Field positions in the modulation control registers
    localparam int          MOD1_MANCH_BIT = 1;
    localparam int          MOD1_SCALE_BIT = 5;
    localparam int          MOD2_KIND_LSB  = 0;
    localparam logic [1:0]  KIND_OOK       = 2'h1;

    // Upper bits of the split fields in the shared offset and gain registers
    localparam int OSR_HI_LSB  = 5;
    localparam int NCO_HI_LSB  = 0;
    localparam int GAIN_HI_LSB = 0;

    // Bus transaction states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACC  = 3'b010,
        ST_RESP = 3'b100
    } ookm_bus_state_type;

endpackage

`default_nettype wire

/* logic/ookm_commit.sv */
`timescale 1ns/1ns
`default_nettype none

// Collects the byte writes of one multi-byte field and fires once all arrived
module ookm_commit #(
    parameter int PARTS = 2
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [PARTS-1:0] part_wr,
    output logic                  commit,
    output logic      [PARTS-1:0] pending
);

    typedef struct packed {
        logic             commit;
        logic [PARTS-1:0] pending;
    } ookm_commit_state_type;

    ookm_commit_state_type cur_ff;
    ookm_commit_state_type nxt_cur;

    // Partial writes are held back so a half-written value never reaches the modem
    always_comb begin
        nxt_cur        = cur_ff;
        nxt_cur.commit = 1'b0;
        if (&(cur_ff.pending | part_wr)) begin
            nxt_cur.commit  = 1'b1;
            nxt_cur.pending = '0;
        end else begin
            nxt_cur.pending = cur_ff.pending | part_wr;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign commit  = cur_ff.commit;
    assign pending = cur_ff.pending;

endmodule

`default_nettype wire

/* logic/ookm_bw_check.sv */
`timescale 1ns/1ns
`default_nettype none

// Flags whether the skip/select pair is one of the keyed-mode bandwidths
module ookm_bw_check (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       ook_mode,
    input  wire logic       skip,
    input  wire logic [3:0] fsel,
    output logic            valid
);

    typedef struct packed {
        logic valid;
    } ookm_bw_state_type;

    ookm_bw_state_type cur_ff;
    ookm_bw_state_type nxt_cur;
    logic              in_list;

    // Without skip: selects 1..7; with skip: 1..4 and 8..15
    always_comb begin
        if (!skip) begin
            in_list = (fsel >= 4'h1) && (fsel <= 4'h7);
        end else begin
            in_list = ((fsel >= 4'h1) && (fsel <= 4'h4)) || (fsel >= 4'h8);
        end
        nxt_cur.valid = ook_mode && in_list;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign valid = cur_ff.valid;

endmodule

`default_nettype wire

/* tb/ookm_host.sv */
`timescale 1ns/1ns
`default_nettype none

// Host controller: bus master that writes the modem configuration
module ookm_host (
    input  wire logic        clk_sys,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
    end

    // One transfer; held until pready is seen high, no latency assumed
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

`default_nettype wire

/* tb/ookm_config_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module ookm_config_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    logic ook_mode, third_stage_skip, bw_valid, rate_scale, manchester_en, e;
    logic [2:0] decim_exp;
    logic [3:0] filter_sel;
    logic [15:0] rate_word, m_rate;
    logic [16:0] eff_rate;
    logic [10:0] osr_ratio, loop_gain, m_osr, m_gain;
    logic [19:0] nco_offset, m_nco;
    logic [7:0] regs [0:127];
    logic [1:0] p_rate, p_osr, p_gain;
    logic [2:0] p_nco;
    logic [7:0] ids [11] = '{8'h1c, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
                             8'h6e, 8'h6f, 8'h70, 8'h71};
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    int rb, man, eff, ex, osr, gain;
    longint nco;

    always #5 clk_sys = ~clk_sys;

    ookm_host ookm_host_inst (.clk_sys(clk_sys), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));

    ookm_config ookm_config_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .ook_mode(ook_mode), .third_stage_skip(third_stage_skip),
        .decim_exp(decim_exp), .filter_sel(filter_sel), .bw_valid(bw_valid),
        .rate_word(rate_word), .rate_scale(rate_scale),
        .manchester_en(manchester_en), .eff_rate(eff_rate), .osr_ratio(osr_ratio),
        .nco_offset(nco_offset), .loop_gain(loop_gain));

    task automatic end_of_test();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask

    // Keyed-mode bandwidth list: 1..7 unskipped, 1..4 and 8..15 skipped
    function automatic logic bw_ok(input logic [7:0] f, input logic k);
        return k && (f[7] ? (f[3:0] inside {[1:4], [8:15]}) : (f[3:0] inside {[1:7]}));
    endfunction

    // Compare every configuration output with the model
    task automatic outs();
        logic k;
        k = (regs[8'h71][1:0] == 2'h1);
        chk("ook_mode", {31'h0, k}, {31'h0, ook_mode});
        chk("skip", {31'h0, regs[8'h1c][7]}, {31'h0, third_stage_skip});
        chk("exp", {29'h0, regs[8'h1c][6:4]}, {29'h0, decim_exp});
        chk("fsel", {28'h0, regs[8'h1c][3:0]}, {28'h0, filter_sel});
        chk("bw_valid", {31'h0, bw_ok(regs[8'h1c], k)}, {31'h0, bw_valid});
        chk("rate", {16'h0, m_rate}, {16'h0, rate_word});
        chk("scale", {31'h0, regs[8'h70][5]}, {31'h0, rate_scale});
        chk("manch", {31'h0, regs[8'h70][1]}, {31'h0, manchester_en});
        chk("eff", {15'h0, m_rate, 1'b0} >> !regs[8'h70][1], {15'h0, eff_rate});
        chk("osr", {21'h0, m_osr}, {21'h0, osr_ratio});
        chk("nco", {12'h0, m_nco}, {12'h0, nco_offset});
        chk("gain", {21'h0, m_gain}, {21'h0, loop_gain});
    endtask

    // Write a byte, update the model with its commit rules, then compare
    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [3:0] s);
        ookm_host_inst.xfer(1'b1, {2'b00, i, 2'b00}, {24'($urandom), d}, s, r, e);
        chk("wr_err", 32'h0, {31'h0, e});
        if (s[0]) begin
            regs[i] = d;
            p_rate |= {i == 8'h6e, i == 8'h6f};
            p_osr |= {i == 8'h21, i == 8'h20};
            p_nco |= {i == 8'h21, i == 8'h22, i == 8'h23};
            p_gain |= {i == 8'h24, i == 8'h25};
        end
        if (&p_rate) {m_rate, p_rate} = {regs[8'h6e], regs[8'h6f], 2'b00};
        if (&p_osr) {m_osr, p_osr} = {regs[8'h21][7:5], regs[8'h20], 2'b00};
        if (&p_nco) {m_nco, p_nco} = {regs[8'h21][3:0], regs[8'h22], regs[8'h23], 3'b0};
        if (&p_gain) {m_gain, p_gain} = {regs[8'h24][2:0], regs[8'h25], 2'b00};
        repeat (3) @(posedge clk_sys);
        outs();
    endtask

    task automatic rd(input logic [7:0] i);
        ookm_host_inst.xfer(1'b0, {2'b00, i, 2'b00}, 32'h0, 4'hf, r, e);
        chk("rd_data", {24'h0, regs[i]}, r);
        chk("rd_err", 32'h0, {31'h0, e});
    endtask

    // Status word built from the model's pending bits and keyed-mode state
    task automatic st();
        logic k;
        k = (regs[8'h71][1:0] == 2'h1);
        ookm_host_inst.xfer(1'b0, 12'h0c0, 32'h0, 4'hf, r, e);
        chk("status", {21'h0, p_nco, p_gain, p_osr, p_rate, bw_ok(regs[8'h1c], k), k}, r);
    endtask

    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(97));
        foreach (regs[j]) regs[j] = 8'h00;
        {m_rate, m_osr, m_nco, m_gain, p_rate, p_osr, p_nco, p_gain} = '0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (ids[j]) rd(ids[j]);
        outs();
        // Unmapped read, misaligned write: refused and without effect
        ookm_host_inst.xfer(1'b0, 12'h000, 32'h0, 4'hf, r, e);
        chk("unmapped", 32'h1, {r[30:0], e});
        ookm_host_inst.xfer(1'b1, 12'h071, 32'hff, 4'hf, r, e);
        chk("misalign", 32'h1, {31'h0, e});
        wr(8'h71, 8'hff, 4'h0);
        // Kind codes 2, 3, 0, 1: ends in keyed mode so the list check below is live
        for (int k = 0; k < 4; k++) wr(8'h71, 8'(k + 2), 4'hf);
        for (int k = 0; k < 32; k++) wr(8'h1c, {k[4], 3'($urandom), k[3:0]}, 4'hf);
        // Partial multi-byte writes must not apply
        wr(8'h6f, 8'($urandom), 4'hf);
        wr(8'h25, 8'($urandom), 4'hf);
        wr(8'h20, 8'($urandom), 4'hf);
        wr(8'h23, 8'($urandom), 4'hf);
        wr(8'h22, 8'($urandom), 4'hf);
        st();
        // Host settings for two keyed-mode rates, with and without coding
        for (int c = 0; c < 2; c++) begin
            rb = c ? 15 : 40;
            man = c;
            eff = rb * (1 + man);
            ex = eff <= 1 ? 5 : eff <= 2 ? 4 : eff <= 3 ? 3 : eff <= 8 ? 2 : eff <= 40 ? 1 : 0;
            osr = (12000 + (eff << ex) / 2) / (eff << ex);
            nco = (longint'(eff) << (20 + ex)) / 1500;
            gain = 2 + (65536 + osr / 2) / osr;
            wr(8'h70, {2'b00, rb <= 30, 3'b000, man[0], 1'b0}, 4'hf);
            wr(8'h1c, {1'b1, ex[2:0], 4'h8}, 4'hf);
            wr(8'h6f, 8'($urandom), 4'hf);
            wr(8'h6e, 8'($urandom), 4'hf);
            wr(8'h20, osr[7:0], 4'hf);
            wr(8'h22, nco[15:8], 4'hf);
            wr(8'h23, nco[7:0], 4'hf);
            // Shared high byte last, so ratio and offset commit with fresh bytes
            wr(8'h21, {osr[10:8], 1'b0, nco[19:16]}, 4'hf);
            wr(8'h25, gain[7:0], 4'hf);
            wr(8'h24, {5'h0, gain[10:8]}, 4'hf);
            chk("osr_doc", c ? 32'hc8 : 32'h96, {21'h0, osr_ratio});
            chk("gain_doc", c ? 32'h14a : 32'h1b7, {21'h0, loop_gain});
        end
        foreach (ids[j]) rd(ids[j]);
        st();
        end_of_test();
    end
endmodule

`default_nettype wire
